// ==== hdl/uart_loop_channel.sv ====
// Purpose: One UART channel: APB registers, 16-bit baud divisor, 8N1 serializer pair and loop-back
// Assumes: clk is the 50 MHz reference clock; serial and modem pins are asynchronous to it
// Notes:   Character format is fixed at 8 data bits, no parity, one stop bit
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/10ps

module uart_loop_channel
  import uart_loop_pkg::*;
(
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset,
  // APB slave
  input  wire uart_loop_pkg::apb_req_type apb_req,
  output uart_loop_pkg::apb_rsp_type      apb_rsp,
  // Serial line
  input  wire logic                       rx_in,
  output logic                            tx_out,
  // Modem pins, active low
  input  wire logic                       cts_n,
  input  wire logic                       dsr_n,
  input  wire logic                       ri_n,
  input  wire logic                       cd_n,
  output logic                            dtr_n,
  output logic                            rts_n,
  // Interrupts
  output logic                            uart_irq,
  output logic                            irq
);
  import uart_loop_pkg::*;

  function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = a[5:2];
  endfunction

  logic [7:0]  interrupt_enable_reg, line_control_reg, modem_control_reg, spr, receive_holding_reg, tx_hold, tx_shift, rx_shift;
  logic [15:0] divisor;
  logic [3:0]  prescale, tx_phase, rx_phase, msr_delta, isr_id, ev_mask;
  logic [EV_W-1:0] ev_status;
  logic [15:0] div_cnt;
  logic [2:0]  tx_bit, rx_bit;
  logic        base_tick, tick16, ready, loop, serial_tx, rx_line;
  logic        thr_empty, thre_pend, data_ready, overrun, framing, brk;
  logic        acc, wr, rd, mapped, tx_load, rx_done;
  logic [1:0]  rx_sync;
  logic [31:0] rdata_q;
  logic [3:0]  modem_s1, modem_s2;
  modem_in_type modem_now, modem_prev;
  tx_state_type tx_state;
  rx_state_type rx_state;
  logic [7:0]  next_rdata;

  assign loop = modem_control_reg[MCR_LOOP];

  // APB: one wait state so read data comes from a flip-flop
  assign acc    = apb_req.psel && apb_req.penable && ready;
  assign wr     = acc && apb_req.pwrite;
  assign rd     = acc && !apb_req.pwrite;
  assign mapped = apb_req.paddr[1:0] == 2'b00 && apb_req.paddr[ADDR_W-1:6] == '0
                  && reg_index(apb_req.paddr) <= IDX_EVMASK;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ready <= 1'b0;
    end else begin
      ready <= apb_req.psel && apb_req.penable && !ready;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    case (reg_index(apb_req.paddr))
      IDX_DATA:   next_rdata = line_control_reg[LCR_DLAB] ? divisor[7:0] : receive_holding_reg;
      IDX_IER:    next_rdata = line_control_reg[LCR_DLAB] ? divisor[15:8] : {4'h0, interrupt_enable_reg[3:0]};
      IDX_ISR:    next_rdata = {4'h0, isr_id};
      IDX_LCR:    next_rdata = line_control_reg;
      IDX_MCR:    next_rdata = {3'b000, modem_control_reg[4:0]};
      IDX_LSR:    next_rdata = {1'b0, thr_empty && tx_state == TX_IDLE, thr_empty, brk, framing, 1'b0, overrun,
                                data_ready};
      IDX_MSR:    next_rdata = {modem_now, msr_delta};
      IDX_SPR:    next_rdata = spr;
      IDX_EVSTAT: next_rdata = {4'h0, ev_status};
      IDX_EVMASK: next_rdata = {4'h0, ev_mask};
      default:    next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_q <= 32'h0000_0000;
    end else if (apb_req.psel && apb_req.penable && !ready) begin
      rdata_q <= {24'h00_0000, mapped ? next_rdata : 8'h00};
    end
  end
  // One driver for the whole response carrier
  assign apb_rsp = '{prdata: rdata_q, pready: ready, pslverr: ready && !mapped};

  // Control registers; the divisor bytes hide behind the latch access bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      interrupt_enable_reg     <= IER_RST;
      line_control_reg     <= LCR_RST;
      modem_control_reg     <= MCR_RST;
      spr     <= SPR_RST;
      divisor <= DIV_RST;
      ev_mask <= 4'h0;
    end else if (wr && mapped) begin
      case (reg_index(apb_req.paddr))
        IDX_DATA:   if (line_control_reg[LCR_DLAB]) divisor[7:0] <= apb_req.pwdata[7:0];
        IDX_IER:    if (line_control_reg[LCR_DLAB]) divisor[15:8] <= apb_req.pwdata[7:0];
                    else interrupt_enable_reg <= {4'h0, apb_req.pwdata[3:0]};
        IDX_LCR:    line_control_reg <= apb_req.pwdata[7:0];
        IDX_MCR:    modem_control_reg <= {3'b000, apb_req.pwdata[4:0]};
        IDX_SPR:    spr <= apb_req.pwdata[7:0];
        IDX_EVMASK: ev_mask <= apb_req.pwdata[EV_W-1:0];
        default:    ;
      endcase
    end
  end

  // Baud generator: prescale by 16, then by the divisor; divisor zero stops the tick
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prescale  <= 4'h0;
      base_tick <= 1'b0;
    end else begin
      prescale  <= prescale + 4'h1;
      base_tick <= prescale == PRESCALE_LAST;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_cnt <= 16'h0000;
      tick16  <= 1'b0;
    end else begin
      tick16 <= 1'b0;
      if (base_tick) begin
        if (divisor != 16'h0000 && div_cnt >= divisor - 16'h0001) begin
          div_cnt <= 16'h0000;
          tick16  <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 16'h0001;
        end
      end
    end
  end

  // Pin synchronisers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_sync  <= 2'b11;
      modem_s1 <= 4'h0;
      modem_s2 <= 4'h0;
    end else begin
      rx_sync  <= {rx_sync[0], rx_in};
      modem_s1 <= {!cd_n, !ri_n, !dsr_n, !cts_n};
      modem_s2 <= modem_s1;
    end
  end

  // Loop-back rewiring of serial path and modem inputs
  assign rx_line   = loop ? serial_tx : rx_sync[1];
  assign tx_out    = loop ? 1'b1 : serial_tx;
  assign dtr_n     = loop ? 1'b1 : !modem_control_reg[MCR_DTR];
  assign rts_n     = loop ? 1'b1 : !modem_control_reg[MCR_RTS];
  assign modem_now = loop ? {modem_control_reg[MCR_INT_EN], modem_control_reg[MCR_OUT1], modem_control_reg[MCR_RTS], modem_control_reg[MCR_DTR]}
                          : modem_in_type'(modem_s2);

  // Transmitter
  assign tx_load = tx_state == TX_IDLE && !thr_empty && tick16;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_state  <= TX_IDLE;
      tx_shift  <= 8'h00;
      tx_phase  <= 4'h0;
      tx_bit    <= 3'h0;
      serial_tx <= 1'b1;
    end else if (tick16) begin
      tx_phase <= tx_phase + 4'h1;
      case (tx_state)
        TX_IDLE: begin
          tx_phase <= 4'h0;
          if (!thr_empty) begin
            tx_shift  <= tx_hold;
            serial_tx <= 1'b0;
            tx_state  <= TX_START;
          end
        end
        TX_START: if (tx_phase == PHASE_LAST) begin
          serial_tx <= tx_shift[0];
          tx_bit    <= 3'h0;
          tx_state  <= TX_DATA;
        end
        TX_DATA: if (tx_phase == PHASE_LAST) begin
          if (tx_bit == BIT_LAST) begin
            serial_tx <= 1'b1;
            tx_state  <= TX_STOP;
          end else begin
            serial_tx <= tx_shift[1];
            tx_shift  <= {1'b0, tx_shift[7:1]};
            tx_bit    <= tx_bit + 3'h1;
          end
        end
        TX_STOP: if (tx_phase == PHASE_LAST) tx_state <= TX_IDLE;
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_hold   <= 8'h00;
      thr_empty <= 1'b1;
      thre_pend <= 1'b0;
    end else if (wr && reg_index(apb_req.paddr) == IDX_DATA && !line_control_reg[LCR_DLAB] && mapped) begin
      tx_hold   <= apb_req.pwdata[7:0];
      thr_empty <= 1'b0;
      thre_pend <= 1'b0;
    end else if (tx_load) begin
      thr_empty <= 1'b1;
      thre_pend <= 1'b1;
    end else if (rd && reg_index(apb_req.paddr) == IDX_ISR && isr_id == ISR_THRE) begin
      thre_pend <= 1'b0;
    end
  end

  // Receiver, sampling mid-bit on the 16x tick
  assign rx_done = tick16 && rx_state == RX_STOP && rx_phase == PHASE_LAST;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_state <= RX_IDLE;
      rx_shift <= 8'h00;
      rx_phase <= 4'h0;
      rx_bit   <= 3'h0;
    end else if (tick16) begin
      rx_phase <= rx_phase + 4'h1;
      case (rx_state)
        RX_IDLE: begin
          rx_phase <= 4'h0;
          if (!rx_line) rx_state <= RX_START;
        end
        RX_START: if (rx_phase == PHASE_MID) begin
          rx_phase <= 4'h0;
          rx_bit   <= 3'h0;
          rx_state <= rx_line ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (rx_phase == PHASE_LAST) begin
          rx_shift <= {rx_line, rx_shift[7:1]};
          rx_bit   <= rx_bit + 3'h1;
          if (rx_bit == BIT_LAST) rx_state <= RX_STOP;
        end
        RX_STOP: if (rx_phase == PHASE_LAST) rx_state <= RX_IDLE;
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // Line status; a new character beats a clearing read in the same cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      receive_holding_reg        <= 8'h00;
      data_ready <= 1'b0;
      overrun    <= 1'b0;
      framing    <= 1'b0;
      brk        <= 1'b0;
    end else begin
      if (rd && mapped && reg_index(apb_req.paddr) == IDX_DATA && !line_control_reg[LCR_DLAB]) data_ready <= 1'b0;
      if (rd && mapped && reg_index(apb_req.paddr) == IDX_LSR) begin
        overrun <= 1'b0;
        framing <= 1'b0;
        brk     <= 1'b0;
      end
      if (rx_done) begin
        receive_holding_reg        <= rx_shift;
        data_ready <= 1'b1;
        if (data_ready) overrun <= 1'b1;
        if (!rx_line) framing <= 1'b1;
        if (!rx_line && rx_shift == 8'h00) brk <= 1'b1;
      end
    end
  end

  // Modem deltas follow whichever source is wired in, so they keep working in loop-back
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      modem_prev <= '0;
      msr_delta  <= 4'h0;
    end else begin
      modem_prev <= modem_now;
      if (rd && mapped && reg_index(apb_req.paddr) == IDX_MSR) msr_delta <= 4'h0;
      if (modem_now != modem_prev) msr_delta <= msr_delta | (modem_now ^ modem_prev);
    end
  end

  // Priority encoder; identical in loop-back, gated by the enables
  always_comb begin
    if (interrupt_enable_reg[IER_LINE] && (overrun || framing || brk)) isr_id = ISR_LINE;
    else if (interrupt_enable_reg[IER_RX] && data_ready) isr_id = ISR_RX;
    else if (interrupt_enable_reg[IER_THRE] && thre_pend && thr_empty) isr_id = ISR_THRE;
    else if (interrupt_enable_reg[IER_MODEM] && msr_delta != 4'h0) isr_id = ISR_MODEM;
    else isr_id = ISR_NONE;
  end
  assign uart_irq = isr_id != ISR_NONE && modem_control_reg[MCR_INT_EN];

  // Sticky event register, write one to clear, the set wins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ev_status <= '0;
    end else begin
      ev_status <= (wr && mapped && reg_index(apb_req.paddr) == IDX_EVSTAT)
                   ? ev_status & ~apb_req.pwdata[EV_W-1:0] : ev_status;
      if (rx_done) ev_status[EV_RX] <= 1'b1;
      if (tx_load) ev_status[EV_TX] <= 1'b1;
      if (rx_done && !rx_line) ev_status[EV_LINE] <= 1'b1;
      if (modem_now != modem_prev) ev_status[EV_MODEM] <= 1'b1;
    end
  end
  assign irq = |(ev_status & ev_mask);

  // Checks
  logic [20:0] gap_cnt;
  logic        gap_ok;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gap_cnt <= '0;
      gap_ok  <= 1'b0;
    end else begin
      gap_cnt <= tick16 ? '0 : gap_cnt + 21'h1;
      if ($changed(divisor)) gap_ok <= 1'b0;
      else if (tick16) gap_ok <= 1'b1;
    end
  end

  sequence seq_loop_steady;
    loop [*2];
  endsequence
  sequence seq_dlm_write;
    wr && mapped && line_control_reg[LCR_DLAB] && reg_index(apb_req.paddr) == IDX_IER;
  endsequence

  a_tick_spacing: assert property (@(posedge clk) disable iff (reset)
    tick16 && gap_ok && $stable(divisor) |-> gap_cnt == {divisor, 4'h0} - 21'h1)
    else $error("16x tick spacing differs from 16 times the divisor");
  a_prescale_gap: assert property (@(posedge clk) disable iff (reset)
    base_tick |=> !base_tick [*8])
    else $error("Prescaler tick came too early");
  a_divisor_high: assert property (@(posedge clk) disable iff (reset)
    seq_dlm_write |=> divisor[15:8] == $past(apb_req.pwdata[7:0]) && $stable(interrupt_enable_reg))
    else $error("Divisor high byte write misrouted");
  a_dlab_gate: assert property (@(posedge clk) disable iff (reset)
    wr && !line_control_reg[LCR_DLAB] |=> $stable(divisor))
    else $error("Divisor changed with latch bit clear");
  a_loop_pins_off: assert property (@(posedge clk) disable iff (reset)
    loop |-> tx_out && dtr_n && rts_n)
    else $error("Pins not released in loop-back");
  a_loop_modem_map: assert property (@(posedge clk) disable iff (reset)
    loop |-> modem_now.cts == modem_control_reg[0] && modem_now.dsr == modem_control_reg[1] && modem_now.ri == modem_control_reg[2] && modem_now.cd == modem_control_reg[3])
    else $error("Loop-back modem wiring wrong");
  a_loop_serial: assert property (@(posedge clk) disable iff (reset)
    loop |-> rx_line == serial_tx)
    else $error("Serial path not joined in loop-back");
  a_loop_delta: assert property (@(posedge clk) disable iff (reset)
    seq_loop_steady ##0 $changed(modem_control_reg[MCR_DTR]) |=> msr_delta[0])
    else $error("Loop-back modem change did not raise delta");
  a_ier_gate: assert property (@(posedge clk) disable iff (reset)
    interrupt_enable_reg[3:0] == 4'h0 |-> !uart_irq)
    else $error("Interrupt raised with all enables clear");
  a_rx_capture: assert property (@(posedge clk) disable iff (reset)
    rx_done |=> data_ready && receive_holding_reg == $past(rx_shift))
    else $error("Received byte not presented");
endmodule

// ==== inc/uart_loop_pkg.sv ====
// Purpose: Shared constants and carriers for the UART channel with baud divisor and loop-back
// Assumes: APB slave with 32-bit data, one register per aligned word, byte address = 4 * index
// Notes:   Register indexes follow the channel's four address bits; 8 and 9 hold the event block
package uart_loop_pkg;
  localparam int ADDR_W = 8;
  // Register indexes (byte address is four times the index)
  localparam logic [3:0] IDX_DATA   = 4'h0; // Receive/transmit holding, divisor low with latch bit
  localparam logic [3:0] IDX_IER    = 4'h1; // Interrupt enable, divisor high with latch bit
  localparam logic [3:0] IDX_ISR    = 4'h2;
  localparam logic [3:0] IDX_LCR    = 4'h3;
  localparam logic [3:0] IDX_MCR    = 4'h4;
  localparam logic [3:0] IDX_LSR    = 4'h5;
  localparam logic [3:0] IDX_MSR    = 4'h6;
  localparam logic [3:0] IDX_SPR    = 4'h7;
  localparam logic [3:0] IDX_EVSTAT = 4'h8;
  localparam logic [3:0] IDX_EVMASK = 4'h9;
  // Field positions
  localparam int LCR_DLAB     = 7;
  localparam int MCR_DTR      = 0;
  localparam int MCR_RTS      = 1;
  localparam int MCR_OUT1     = 2;
  localparam int MCR_INT_EN   = 3;
  localparam int MCR_LOOP     = 4;
  localparam int IER_RX       = 0;
  localparam int IER_THRE     = 1;
  localparam int IER_LINE     = 2;
  localparam int IER_MODEM    = 3;
  // Reset values
  localparam logic [7:0]  IER_RST = 8'h00;
  localparam logic [7:0]  LCR_RST = 8'h00;
  localparam logic [7:0]  MCR_RST = 8'h00;
  localparam logic [7:0]  SPR_RST = 8'hff;
  localparam logic [15:0] DIV_RST = 16'h0001; // Undefined at power-up; one is a safe start
  // Interrupt identification codes
  localparam logic [3:0] ISR_NONE  = 4'h1;
  localparam logic [3:0] ISR_LINE  = 4'h6;
  localparam logic [3:0] ISR_RX    = 4'h4;
  localparam logic [3:0] ISR_THRE  = 4'h2;
  localparam logic [3:0] ISR_MODEM = 4'h0;
  // Event bits of the sticky event register
  localparam int EV_RX    = 0;
  localparam int EV_TX    = 1;
  localparam int EV_LINE  = 2;
  localparam int EV_MODEM = 3;
  localparam int EV_W     = 4;
  // Timing
  localparam logic [3:0] PRESCALE_LAST = 4'hf; // Reference clock divided by 16
  localparam logic [3:0] PHASE_LAST    = 4'hf; // Sixteen samples per bit
  localparam logic [3:0] PHASE_MID     = 4'h7;
  localparam logic [2:0] BIT_LAST      = 3'h7;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_type;

  // Modem inputs as active-high levels: carrier detect, ring, data set ready, clear to send
  typedef struct packed {
    logic cd;
    logic ri;
    logic dsr;
    logic cts;
  } modem_in_type;

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_type;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_type;
endpackage

// ==== tb/line_far_end.sv ====
// Purpose: Far end of the serial line and modem pins for the channel bench
// Assumes: noisy is raised only while the channel sits in loop-back
// Notes:   Noise flips every cycle, so any leak from a pin into the channel shows up at once
`timescale 1ns/10ps
module line_far_end (
  // Clock
  input  wire logic       clk,
  // Control from the bench, modem levels in order cd ri dsr cts
  input  wire logic       noisy,
  input  wire logic [3:0] modem_n,
  // Serial line
  input  wire logic       tx_out,
  output logic            rx_in,
  // Modem inputs, active low
  output logic            cd_n,
  output logic            ri_n,
  output logic            dsr_n,
  output logic            cts_n
);
  logic toggle = 1'b0;

  always @(posedge clk) begin
    toggle <= !toggle;
  end
  // Echo keeps a normal-mode transfer honest; in loop-back the pin carries noise instead
  assign rx_in = noisy ? toggle : tx_out;
  assign {cd_n, ri_n, dsr_n, cts_n} = noisy ? {4{toggle}} : modem_n;
endmodule

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the UART channel: divisor, loop-back, events and interrupts
// Assumes: APB slave answers within a few cycles; fixed 8N1 framing
// Notes:   Expected bytes come from a queue model; expected levels are worked out here
`timescale 1ns/10ps
module tb_top;
  import uart_loop_pkg::*;
  logic        clk      = 1'b0;
  logic        reset    = 1'b1;
  apb_req_type req      = '0;
  apb_rsp_type rsp;
  logic        rx_in, tx_out, cts_n, dsr_n, ri_n, cd_n, dtr_n, rts_n, uart_irq, irq;
  logic        noisy    = 1'b0;
  logic [3:0]  modem_n  = 4'hf;
  int          error_cnt = 0;
  int          n_checks  = 0;
  int          tx_bad    = 0;
  logic [7:0]  sent_q[$];
  logic [7:0]  rst_addr[6] = '{8'h04, 8'h0c, 8'h10, 8'h1c, 8'h14, 8'h08};
  logic [7:0]  rst_val[6]  = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h60, 8'h01};
  logic [15:0] divs[4]     = '{16'h0900, 16'h0417, 16'hffff, 16'h0002};

  always #10 clk = !clk;

  uart_loop_channel uart_loop_channel_i (
    .clk(clk), .reset(reset), .apb_req(req), .apb_rsp(rsp), .rx_in(rx_in), .tx_out(tx_out),
    .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n), .dtr_n(dtr_n), .rts_n(rts_n),
    .uart_irq(uart_irq), .irq(irq));

  line_far_end line_far_end_i (
    .clk(clk), .noisy(noisy), .modem_n(modem_n), .tx_out(tx_out), .rx_in(rx_in),
    .cd_n(cd_n), .ri_n(ri_n), .dsr_n(dsr_n), .cts_n(cts_n));

  // Pins must stay parked high for the whole loop-back stretch
  always @(posedge clk) begin
    if (noisy && {tx_out, dtr_n, rts_n} !== 3'b111) tx_bad <= tx_bad + 1;
  end

  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge clk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= a;
    req.pwdata  <= {24'h000000, d};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    if (n >= 50) chk(n, 0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] v;
    logic        e;
    apb(1'b1, a, d, v, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic        e;
    apb(1'b0, a, 8'h00, v, e);
    chk(v, exp);
  endtask

  task automatic send(input logic [7:0] b);
    wr(8'h00, b);
    sent_q.push_back(b);
  endtask

  task automatic wait_dr();
    logic [31:0] v;
    logic        e;
    int          n;
    n = 0;
    do begin
      apb(1'b0, 8'h14, 8'h00, v, e);
      n++;
    end while (v[0] !== 1'b1 && n < 3000);
    chk(v[0], 1'b1);
  endtask

  task automatic take_rhr();
    rd_chk(8'h00, {24'h000000, sent_q.pop_front()});
  endtask

  initial begin
    #2000000;
    chk(1'b0, 1'b1);
    report_and_stop();
  end

  initial begin
    logic [31:0] v;
    logic        e;
    logic [7:0]  b;
    logic [3:0]  m, prev;
    int          w;
    void'($urandom(32'hb83b887e));
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk({tx_out, dtr_n, rts_n, irq, uart_irq}, 5'b11100);
    foreach (rst_addr[i]) rd_chk(rst_addr[i], {24'h000000, rst_val[i]});
    apb(1'b0, 8'h28, 8'h00, v, e);
    chk({e, v[7:0]}, 9'h100);
    wr(8'h0c, 8'h80);
    foreach (divs[i]) begin
      wr(8'h04, divs[i][15:8]);
      wr(8'h00, divs[i][7:0]);
      rd_chk(8'h04, {24'h000000, divs[i][15:8]});
      rd_chk(8'h00, {24'h000000, divs[i][7:0]});
    end
    wr(8'h0c, 8'h00);
    rd_chk(8'h04, 32'h00000000);
    wr(8'h04, 8'h05);
    wr(8'h0c, 8'h80);
    rd_chk(8'h04, 32'h00000000);
    wr(8'h0c, 8'h00);
    rd_chk(8'h04, 32'h00000005);
    wr(8'h04, 8'h00);
    // Normal mode at divisor 2: the far end echoes the line back
    m = 4'($urandom);
    modem_n <= m;
    wr(8'h10, 8'h03);
    @(negedge clk);
    chk({dtr_n, rts_n, tx_out}, 3'b001);
    b = 8'($urandom) | 8'h01;
    send(b);
    w = 0;
    while (tx_out !== 1'b0 && w < 4000) begin
      @(posedge clk);
      w++;
    end
    w = 0;
    while (tx_out === 1'b0 && w < 4000) begin
      @(posedge clk);
      w++;
    end
    chk(w, 512);
    wait_dr();
    take_rhr();
    rd_chk(8'h18, {24'h000000, ~m, ~m});
    // Loop-back with noisy pins
    wr(8'h0c, 8'h80);
    wr(8'h00, 8'h01);
    wr(8'h0c, 8'h00);
    wr(8'h10, 8'h10);
    noisy <= 1'b1;
    apb(1'b0, 8'h18, 8'h00, v, e);
    wr(8'h24, 8'h00);
    wr(8'h20, 8'h0f);
    send(8'($urandom));
    wait_dr();
    take_rhr();
    rd_chk(8'h20, 32'h00000003);
    chk(irq, 1'b0);
    wr(8'h24, 8'h01);
    @(negedge clk);
    chk(irq, 1'b1);
    wr(8'h20, 8'h0f);
    @(negedge clk);
    chk(irq, 1'b0);
    prev = 4'h0;
    for (int i = 0; i < 16; i++) begin
      m = 4'(i);
      wr(8'h10, {4'h1, m});
      repeat (6) @(posedge clk);
      rd_chk(8'h18, {24'h000000, m, m ^ prev});
      prev = m;
    end
    // Interrupt gating by the enable register
    wr(8'h10, 8'h18);
    repeat (6) @(posedge clk);
    apb(1'b0, 8'h18, 8'h00, v, e);
    wr(8'h04, 8'h01);
    @(negedge clk);
    chk(uart_irq, 1'b0);
    send(8'($urandom));
    wait_dr();
    chk(uart_irq, 1'b1);
    rd_chk(8'h08, {28'h0, ISR_RX});
    take_rhr();
    @(negedge clk);
    chk(uart_irq, 1'b0);
    wr(8'h04, 8'h08);
    @(negedge clk);
    chk(uart_irq, 1'b0);
    wr(8'h10, 8'h19);
    repeat (6) @(posedge clk);
    chk(uart_irq, 1'b1);
    rd_chk(8'h08, {28'h0, ISR_MODEM});
    wr(8'h04, 8'h00);
    @(negedge clk);
    chk(uart_irq, 1'b0);
    chk(tx_bad, 0);
    noisy <= 1'b0;
    wr(8'h10, 8'h00);
    report_and_stop();
  end
endmodule
